// >>> tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// register byte offsets
`define REG_EDGE_CFG     12'h000
`define REG_EDGE_CLR     12'h004
`define REG_UP_CTRL      12'h008
`define REG_UP_MS        12'h00c
`define REG_UP_SEC       12'h010
`define REG_UP_MIN       12'h014
`define REG_UP_HOUR      12'h018
`define REG_UP_DAY       12'h01c
`define REG_UP_TOTAL     12'h020
`define REG_EVT_STAT     12'h024
`define REG_WAIT         12'h028
`define REG_KEY_CTRL     12'h02c
`define REG_CD_PERIOD    12'h030
`define REG_CD_REPEAT    12'h034
`define REG_CD_LOAD      12'h038
`define REG_EDGE_BASE    12'h100
`define REG_CD_BASE      12'h200
// timing
`define CLK_HZ           40000000
`define TICK_US          1000
`define TICK_CYCLES      ((`CLK_HZ / 1000000) * `TICK_US)
`define MS_WRAP          10'd999
`define SM_WRAP          6'd59
`define HOUR_WRAP        5'd23
`endif

// >>> tmr_pkg.sv
package tmr_pkg;
    typedef struct packed {
        logic        ms;
        logic        sec;
        logic        min;
        logic        hour;
        logic        day;
    } wrap_evt_t;
    typedef enum logic [1:0] {
        WAIT_IDLE = 2'b00,
        WAIT_RUN  = 2'b01
    } wait_state_t;
endpackage

// >>> edge_counters_runtime_and_timers.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tmr_consts.svh"
// Operation
// - twenty-four 32-bit edge counters, one per input line, readable by software.
// - each counter increments once on its line's configured active edge.
// - clearing one edge counter leaves the other twenty-three untouched.
// - counters keep up with edge rates of at least 10 kHz.
// - uptime reset zeroes all uptime fields and counting restarts at once.
// - uptime counter runs from system reset with no configuration needed.
// - millisecond field steps once per millisecond through 0 to 999.
// - seconds and minutes cycle 0-59, hours 0-23, days count on carry.
// - total field counts every millisecond since reset.
// - each uptime field except the total pulses its own wrap event on rollover.
// - ten millisecond countdown units, each with its own expiry event.
// - reading a countdown unit returns milliseconds remaining.
// - period-only load expires once then stops.
// - repeat count n reloads until n expiries; zero means forever.
// - loading a zero period clears the unit and pending repeats.
// - wait holds command processing for the requested milliseconds.
// - events keep being detected and serviced during a wait.
// - key presses arriving while a key handler runs are discarded.
module edge_counters_runtime_and_timers #(
    parameter int                N_LINES = 24,
    parameter int                N_CD    = 10,
    parameter logic [15:0]       TICK_CYC = 16'(`TICK_CYCLES)
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic [N_LINES-1:0]   input_line_i,
    input  wire logic                 key_press_i,
    output logic                      key_accept_o,
    output logic                      cmd_hold_o,
    output tmr_pkg::wrap_evt_t        wrap_evt_o,
    output logic      [N_CD-1:0]      cd_expire_o
);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire        wr_en   = psel_i & penable_i & pwrite_i;
    wire        rd_en   = psel_i & penable_i & ~pwrite_i;
    wire        edge_hit = (paddr_i[11:8] == 4'h1) && (paddr_i[7:2] < 6'(N_LINES));
    wire        cd_hit   = (paddr_i[11:8] == 4'h2) && (paddr_i[7:2] < 6'(N_CD));
    wire [5:0]  sel_idx  = paddr_i[7:2];
    // every register answers in its access cycle, so no wait states are needed
    assign pready_o = 1'b1;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // a line with its enable bit clear never counts, whatever its edge select
    logic [N_LINES-1:0] src_en;       // line enabled as event source
    logic [N_LINES-1:0] edge_fall;    // 1 = falling edge counts
    logic [31:0]        cd_period;
    logic [31:0]        cd_repeat;
    logic               key_busy;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_en    <= '0;
            edge_fall <= '0;
            cd_period <= 32'h0;
            cd_repeat <= 32'h0;
            key_busy  <= 1'b0;
        end else begin
            if (wr_en && paddr_i == `REG_EDGE_CFG) begin
                src_en <= pwdata_i[N_LINES-1:0];
            end
            if (wr_en && paddr_i == `REG_UP_CTRL) begin
                edge_fall <= pwdata_i[N_LINES-1:0];
            end
            if (wr_en && paddr_i == `REG_CD_PERIOD) begin
                cd_period <= pwdata_i;
            end
            if (wr_en && paddr_i == `REG_CD_REPEAT) begin
                cd_repeat <= pwdata_i;
            end
            // a press taken in the cycle of a handler end still marks busy;
            // the set wins so that the new handler never runs unmarked
            if (key_accept_o) begin
                key_busy <= 1'b1;
            end else if (wr_en && paddr_i == `REG_KEY_CTRL && pwdata_i[0]) begin
                key_busy <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // input synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [N_LINES-1:0] line_s1;
    logic [N_LINES-1:0] line_s2;
    logic [N_LINES-1:0] line_d;
    logic [1:0]         key_s;
    logic               key_d;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_s1 <= '0;
            line_s2 <= '0;
            line_d  <= '0;
            key_s   <= 2'b00;
            key_d   <= 1'b0;
        end else begin
            line_s1 <= input_line_i;
            line_s2 <= line_s1;
            line_d  <= line_s2;
            key_s   <= {key_s[0], key_press_i};
            key_d   <= key_s[1];
        end
    end
    // edges are sampled every clock, far above the guaranteed rate
    wire [N_LINES-1:0] rise = line_s2 & ~line_d;
    wire [N_LINES-1:0] fall = ~line_s2 & line_d;
    wire [N_LINES-1:0] hit  = src_en & ((rise & ~edge_fall) | (fall & edge_fall));
    // presses during a running handler are dropped, not queued
    assign key_accept_o = key_s[1] & ~key_d & ~key_busy;

    // ----------------------------------------------------------------
    // edge counters
    // ----------------------------------------------------------------
    logic [31:0] input_edge_count [N_LINES];
    wire         clr_one = wr_en && paddr_i == `REG_EDGE_CLR;
    // a clear and an edge in one cycle: the clear wins and that edge is lost
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N_LINES; i++) begin
                input_edge_count[i] <= 32'h0;
            end
        end else begin
            for (int i = 0; i < N_LINES; i++) begin
                if (clr_one && pwdata_i[4:0] == 5'(i)) begin
                    input_edge_count[i] <= 32'h0;
                end else if (hit[i]) begin
                    input_edge_count[i] <= input_edge_count[i] + 32'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // millisecond time base
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt;
    wire         tick = (tick_cnt == TICK_CYC - 16'h1);
    wire         up_rst = wr_en && paddr_i == `REG_UP_TOTAL;
    // the uptime reset restarts the prescaler too, so the first ms is full length
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt <= 16'h0;
        end else if (tick || up_rst) begin
            tick_cnt <= 16'h0;
        end else begin
            tick_cnt <= tick_cnt + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // uptime counter
    // ----------------------------------------------------------------
    logic [9:0]  uptime_millisecond_field;
    logic [5:0]  uptime_second_field;
    logic [5:0]  uptime_minute_field;
    logic [4:0]  uptime_hour_field;
    logic [31:0] uptime_day_field;
    logic [31:0] uptime_total_ms;
    // carries ripple combinationally so every field steps on the same tick
    wire ms_w  = tick && uptime_millisecond_field == `MS_WRAP;
    wire sec_w = ms_w && uptime_second_field == `SM_WRAP;
    wire min_w = sec_w && uptime_minute_field == `SM_WRAP;
    wire hr_w  = min_w && uptime_hour_field == `HOUR_WRAP;
    wire day_w = hr_w && uptime_day_field == 32'hffffffff;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uptime_millisecond_field <= 10'h0;
            uptime_second_field      <= 6'h0;
            uptime_minute_field      <= 6'h0;
            uptime_hour_field        <= 5'h0;
            uptime_day_field         <= 32'h0;
            uptime_total_ms          <= 32'h0;
            wrap_evt_o               <= '0;
        end else if (up_rst) begin
            uptime_millisecond_field <= 10'h0;
            uptime_second_field      <= 6'h0;
            uptime_minute_field      <= 6'h0;
            uptime_hour_field        <= 5'h0;
            uptime_day_field         <= 32'h0;
            uptime_total_ms          <= 32'h0;
            wrap_evt_o               <= '0;
        end else begin
            wrap_evt_o <= '{ms: ms_w, sec: sec_w, min: min_w, hour: hr_w, day: day_w};
            if (tick) begin
                uptime_total_ms          <= uptime_total_ms + 32'h1;
                uptime_millisecond_field <= ms_w ? 10'h0 : uptime_millisecond_field + 10'h1;
            end
            if (ms_w) begin
                uptime_second_field <= sec_w ? 6'h0 : uptime_second_field + 6'h1;
            end
            if (sec_w) begin
                uptime_minute_field <= min_w ? 6'h0 : uptime_minute_field + 6'h1;
            end
            if (min_w) begin
                uptime_hour_field <= hr_w ? 5'h0 : uptime_hour_field + 5'h1;
            end
            if (hr_w) begin
                uptime_day_field <= uptime_day_field + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // countdown units
    // ----------------------------------------------------------------
    logic [31:0] cd_remain [N_CD];
    logic [31:0] cd_left   [N_CD];   // expiries still to go, 0 = forever
    logic [31:0] cd_reload [N_CD];
    logic [N_CD-1:0] cd_run;
    wire  cd_load = wr_en && paddr_i == `REG_CD_LOAD;
    // a load in the cycle of an expiry wins; the old countdown is dropped
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cd_run      <= '0;
            cd_expire_o <= '0;
            for (int i = 0; i < N_CD; i++) begin
                cd_remain[i] <= 32'h0;
                cd_left[i]   <= 32'h0;
                cd_reload[i] <= 32'h0;
            end
        end else begin
            for (int i = 0; i < N_CD; i++) begin
                cd_expire_o[i] <= 1'b0;
                if (cd_load && pwdata_i[3:0] == 4'(i)) begin
                    cd_remain[i] <= cd_period;
                    cd_reload[i] <= cd_period;
                    // a repeat of 0 written with a period means endless
                    cd_left[i]   <= pwdata_i[4] ? cd_repeat : 32'h1;
                    cd_run[i]    <= (cd_period != 32'h0);
                end else if (cd_run[i] && tick) begin
                    if (cd_remain[i] == 32'h1) begin
                        cd_expire_o[i] <= 1'b1;
                        if (cd_left[i] == 32'h1) begin
                            cd_run[i]    <= 1'b0;
                            cd_remain[i] <= 32'h0;
                        end else begin
                            cd_remain[i] <= cd_reload[i];
                            if (cd_left[i] != 32'h0) begin
                                cd_left[i] <= cd_left[i] - 32'h1;
                            end
                        end
                    end else begin
                        cd_remain[i] <= cd_remain[i] - 32'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // wait service
    // ----------------------------------------------------------------
    // a zero request is ignored rather than taken as an endless wait
    tmr_pkg::wait_state_t wait_st;
    logic [31:0]          wait_left;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_st   <= tmr_pkg::WAIT_IDLE;
            wait_left <= 32'h0;
        end else begin
            case (wait_st)
                tmr_pkg::WAIT_IDLE: begin
                    if (wr_en && paddr_i == `REG_WAIT && pwdata_i != 32'h0) begin
                        wait_left <= pwdata_i;
                        wait_st   <= tmr_pkg::WAIT_RUN;
                    end
                end
                tmr_pkg::WAIT_RUN: begin
                    // only the command path stalls; counters run on
                    if (tick) begin
                        wait_left <= wait_left - 32'h1;
                        if (wait_left == 32'h1) begin
                            wait_st <= tmr_pkg::WAIT_IDLE;
                        end
                    end
                end
                default: wait_st <= tmr_pkg::WAIT_IDLE;
            endcase
        end
    end
    assign cmd_hold_o = (wait_st == tmr_pkg::WAIT_RUN);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        if (edge_hit) begin
            rd_val = input_edge_count[sel_idx[4:0]];
        end else if (cd_hit) begin
            rd_val = cd_remain[sel_idx[3:0]];
        end else begin
            case (paddr_i)
                `REG_EDGE_CFG:  rd_val = 32'(src_en);
                `REG_EDGE_CLR:  rd_val = 32'h0;
                `REG_UP_CTRL:   rd_val = 32'(edge_fall);
                `REG_UP_MS:     rd_val = 32'(uptime_millisecond_field);
                `REG_UP_SEC:    rd_val = 32'(uptime_second_field);
                `REG_UP_MIN:    rd_val = 32'(uptime_minute_field);
                `REG_UP_HOUR:   rd_val = 32'(uptime_hour_field);
                `REG_UP_DAY:    rd_val = uptime_day_field;
                `REG_UP_TOTAL:  rd_val = uptime_total_ms;
                `REG_EVT_STAT:  rd_val = 32'(cd_run);
                `REG_WAIT:      rd_val = wait_left;
                `REG_KEY_CTRL:  rd_val = {31'h0, key_busy};
                `REG_CD_PERIOD: rd_val = cd_period;
                `REG_CD_REPEAT: rd_val = cd_repeat;
                `REG_CD_LOAD:   rd_val = 32'h0;
                default:        rd_ok  = 1'b0;
            endcase
        end
    end
    // read data is captured in the setup cycle and stands until the next read
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_val;
        end
    end
    assign pslverr_o = psel_i & penable_i & ~rd_ok;
    wire unused_rd = rd_en;
endmodule

// >>> edge_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side input line driver
// ----------------------------------------
module edge_src (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [4:0]  idx_i,
    input  wire logic [7:0]  tog_i,
    input  wire logic [7:0]  gap_i,
    output logic      [23:0] line_o,
    output logic             busy_o
);
    logic [7:0] left;
    logic [7:0] cnt;
    initial begin
        line_o = '0;
        busy_o = 1'b0;
        left = '0;
        cnt = '0;
    end
    // toggles one line tog_i times; gap_i sets how slowly edges come
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            left <= tog_i;
            busy_o <= (tog_i != 8'h00);
            cnt <= gap_i;
        end else if (busy_o) begin
            if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else begin
                line_o[idx_i] <= ~line_o[idx_i];
                cnt <= gap_i;
                left <= left - 8'h01;
                busy_o <= (left != 8'h01);
            end
        end
    end
endmodule

// >>> edge_counters_runtime_and_timers_asserts.sv
`timescale 1ns/1ps
`include "tmr_consts.svh"
// ----------------------------------------
// port-level checks
// ----------------------------------------
module edge_counters_runtime_and_timers_asserts #(
    parameter int          N_CD     = 10,
    parameter logic [15:0] TICK_CYC = 16'h0008
) (
    input wire logic               mclk_i,
    input wire logic               rst_n_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic               pwrite_i,
    input wire logic [11:0]        paddr_i,
    input wire logic [31:0]        pwdata_i,
    input wire logic               pready_o,
    input wire logic               pslverr_o,
    input wire logic               key_accept_o,
    input wire logic               cmd_hold_o,
    input wire tmr_pkg::wrap_evt_t wrap_evt_o,
    input wire logic [N_CD-1:0]    cd_expire_o
);
    localparam int MS_LO = 1000 * int'(TICK_CYC) - 3;
    localparam int MS_HI = 1000 * int'(TICK_CYC) + 3;
    wire  acc = psel_i && penable_i;
    wire  up_rst = acc && pwrite_i && paddr_i == `REG_UP_TOTAL;
    logic        busy_m;
    logic        wait_wr_q;
    logic [31:0] ms_gap;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence wait_req_s;
        acc && pwrite_i && paddr_i == `REG_WAIT && pwdata_i != 32'h0;
    endsequence
    // shadow of key handler busy; a new press wins over a handler-end write
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_m <= 1'b0;
            wait_wr_q <= 1'b0;
            ms_gap <= '0;
        end else begin
            busy_m <= key_accept_o || (busy_m && !(acc && pwrite_i && paddr_i == `REG_KEY_CTRL && pwdata_i[0]));
            wait_wr_q <= acc && pwrite_i && paddr_i == `REG_WAIT;
            ms_gap <= (wrap_evt_o.ms || up_rst) ? 32'h0 : ms_gap + 32'h1;
        end
    end
    rdy_high_a: assert property (acc |-> pready_o) else $error("pready low in access");
    err_place_a: assert property (pslverr_o |-> acc) else $error("pslverr outside access");
    err_map_a: assert property (acc && paddr_i == `REG_UP_MS |-> !pslverr_o) else $error("mapped address refused");
    hold_start_a: assert property (wait_req_s |=> cmd_hold_o) else $error("wait did not hold");
    hold_cause_a: assert property ($rose(cmd_hold_o) |-> wait_wr_q) else $error("hold without wait");
    key_busy_a: assert property (key_accept_o |-> !busy_m) else $error("key taken while busy");
    ms_early_a: assert property (wrap_evt_o.ms |-> ms_gap >= MS_LO) else $error("ms wrap early");
    ms_late_a: assert property (ms_gap <= MS_HI) else $error("ms wrap late");
    cd_pulse_a: assert property (cd_expire_o != '0 |=> (cd_expire_o & $past(cd_expire_o)) == '0)
        else $error("expiry pulse too long");
endmodule
bind edge_counters_runtime_and_timers edge_counters_runtime_and_timers_asserts #(
    .N_CD(N_CD), .TICK_CYC(TICK_CYC)) i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .key_accept_o(key_accept_o),
    .cmd_hold_o(cmd_hold_o), .wrap_evt_o(wrap_evt_o), .cd_expire_o(cd_expire_o));

// >>> edge_counters_runtime_and_timers_bench.sv
`timescale 1ns/1ps
`include "tmr_consts.svh"
module edge_counters_runtime_and_timers_bench;
    localparam int T = 8;
    logic               mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rdq;
    logic               rde, key, key_acc, hold, go, src_busy;
    logic [23:0]        lines;
    logic [9:0]         cd_exp;
    logic [4:0]         idx;
    logic [7:0]         tog;
    tmr_pkg::wrap_evt_t wrap;
    int fails, num_checks, key_n, hold_n, h0, n, k;
    int exp_n[10];
    // ordinary cases: line, toggles, expected count (line 5 left disabled)
    int r_idx[4] = '{0, 23, 7, 5};
    int r_tog[4] = '{5, 5, 4, 2};
    int r_exp[4] = '{3, 2, 2, 0};
    edge_counters_runtime_and_timers #(.TICK_CYC(16'h0008)) i_edge_counters_runtime_and_timers (
        .mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .input_line_i(lines), .key_press_i(key), .key_accept_o(key_acc), .cmd_hold_o(hold),
        .wrap_evt_o(wrap), .cd_expire_o(cd_exp));
    edge_src i_edge_src (.clk_i(mclk), .go_i(go), .idx_i(idx), .tog_i(tog), .gap_i(8'h03),
        .line_o(lines), .busy_o(src_busy));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // event tallies taken mid-cycle, where the outputs have settled
    always @(negedge mclk) begin
        for (int i = 0; i < 10; i++) exp_n[i] += int'(cd_exp[i]);
        key_n += int'(key_acc);
        hold_n += int'(hold);
    end
    task give_verdict;
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task limit(input int c, input int lim);
        if (c >= lim) begin
            fails++;
            give_verdict;
        end
    endtask
    // one apb transfer; entered just after an edge, leaves one idle cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int c;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge mclk);
            c++;
        end while (pready !== 1'b1 && c < 20);
        limit(c, 20);
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(rdq, want);
    endtask
    task toggle(input int i, input int t);
        idx <= 5'(i);
        tog <= 8'(t);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (src_busy !== 1'b0 && k < 500);
        limit(k, 500);
        repeat (4) @(posedge mclk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, key, go} = '0;
        paddr = '0;
        pwdata = '0;
        idx = '0;
        tog = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdc(`REG_EDGE_BASE, 32'h0);
        rdc(`REG_UP_MIN, 32'h0);
        apb(1'b1, `REG_EDGE_CFG, 32'h00ffffdf);
        apb(1'b1, 12'h008, 32'h00800000);
        for (int i = 0; i < 4; i++) begin
            toggle(r_idx[i], r_tog[i]);
            rdc(12'(`REG_EDGE_BASE + 4 * r_idx[i]), 32'(r_exp[i]));
        end
        apb(1'b1, `REG_EDGE_CLR, 32'h0);
        rdc(`REG_EDGE_BASE, 32'h0);
        rdc(12'h15c, 32'h2);
        apb(1'b0, 12'h3fc, 32'h0);
        chk(32'(rde), 32'h1);
        chk(rdq, 32'h0);
        // countdown once, repeated, forever then cleared
        apb(1'b1, `REG_CD_PERIOD, 32'h3);
        apb(1'b1, `REG_CD_LOAD, 32'h2);
        apb(1'b0, 12'h208, 32'h0);
        chk(32'(rdq inside {2, 3}), 32'h1);
        repeat (8 * T) @(posedge mclk);
        chk(32'(exp_n[2]), 32'h1);
        apb(1'b1, `REG_CD_REPEAT, 32'h2);
        apb(1'b1, `REG_CD_PERIOD, 32'h2);
        apb(1'b1, `REG_CD_LOAD, 32'h14);
        repeat (8 * T) @(posedge mclk);
        chk(32'(exp_n[4]), 32'h2);
        apb(1'b1, `REG_CD_REPEAT, 32'h0);
        apb(1'b1, `REG_CD_LOAD, 32'h15);
        repeat (7 * T) @(posedge mclk);
        chk(32'(exp_n[5] >= 2), 32'h1);
        apb(1'b1, `REG_CD_PERIOD, 32'h0);
        apb(1'b1, `REG_CD_LOAD, 32'h15);
        n = exp_n[5];
        repeat (5 * T) @(posedge mclk);
        chk(32'(exp_n[5]), 32'(n));
        rdc(12'h214, 32'h0);
        // wait with key presses meanwhile
        apb(1'b1, `REG_WAIT, 32'h4);
        h0 = hold_n;
        key <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(key_n), 32'h1);
        key <= 1'b0;
        repeat (4) @(posedge mclk);
        key <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(key_n), 32'h1);
        key <= 1'b0;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hold !== 1'b0 && k < 100);
        limit(k, 100);
        chk(32'((hold_n - h0) inside {[3 * T : 4 * T + 2]}), 32'h1);
        apb(1'b1, `REG_KEY_CTRL, 32'h1);
        key <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(key_n), 32'h2);
        // uptime rollover then restart
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wrap.ms !== 1'b1 && k < 9000);
        limit(k, 9000);
        chk(32'(wrap.sec), 32'h0);
        rdc(`REG_UP_SEC, 32'h1);
        apb(1'b0, `REG_UP_MS, 32'h0);
        chk(32'(rdq < 2), 32'h1);
        apb(1'b0, `REG_UP_TOTAL, 32'h0);
        chk(32'(rdq inside {1000, 1001}), 32'h1);
        apb(1'b1, `REG_UP_TOTAL, 32'h0);
        rdc(`REG_UP_SEC, 32'h0);
        repeat (5 * T) @(posedge mclk);
        apb(1'b0, `REG_UP_TOTAL, 32'h0);
        chk(32'(rdq inside {[4 : 6]}), 32'h1);
        give_verdict;
    end
endmodule
